//--- irq_ctrl.sv
// multi-level interrupt controller with vector generation
// Behaviour
// - three levels high, medium, low; each source carries its own level
// - medium request pre-empts a running low-level service routine
// - high request pre-empts running low or medium service routines
// - low level arbitration fixed or round-robin, round-robin bounds wait
// - oscillator failure interrupt is taken regardless of level enables
// - oscillator failure dispatches to word address 0x002
// - sources 0 to 22 each have a distinct vector base; source 23 falls back to the reset address 0x000
// - vector equals peripheral base plus interrupt offset; SPI C and SPI D ignore the offset
// - vectors are word addresses, reset entry at 0x000
// - whole table may be moved to the boot section start
// - port C pins 0x004, port R 0x008, port B 0x044
// - port D pins 0x080, port A 0x084, port F 0x0D0
// - timer C0 0x01C, timer C1 0x028, timer E0 0x05E
// - timer D0 0x09A, timer F0 0x0D8, comparator A 0x088
// - SPI C fixed at 0x030, SPI D fixed at 0x0AE
// - TWI C 0x018, TWI E 0x05A, USART C0 0x032
// - USART E0 0x074, USART D0 0x0B0, port E pins 0x056
// - RTC 0x014, NVM 0x040, converter A 0x08E
module irq_ctrl #(
   parameter int NSRC = irq_ctrl_pkg::NSRC,
   parameter logic [11:0] BOOT_BASE = irq_ctrl_pkg::BOOT_BASE_DEFAULT
) (
   input wire logic clock, // system clock
   input wire logic sys_rst, // async reset, active high
   input irq_ctrl_pkg::src_req_t src [NSRC], // held requests
   input wire logic osc_fail, // oscillator failure level
   input wire logic lo_en, // low level enable
   input wire logic med_en, // medium level enable
   input wire logic hi_en, // high level enable
   input wire logic rr_en, // round-robin for low level
   input wire logic vec_in_boot, // table at boot section start
   input wire logic vec_ack, // core took the vector
   input wire logic reti, // core returned from a routine
   output irq_ctrl_pkg::vec_out_t vec, // vector toward the core
   output logic [NSRC-1:0] src_taken, // pulse: source serviced
   output logic lo_active, // low routine running
   output logic med_active, // medium routine running
   output logic hi_active, // high routine running
   output logic nmi_active // nmi routine running
);

   // ****************************************
   // vector table
   // ****************************************
   function automatic logic [11:0] base_of(input logic [4:0] i);
      unique case (i)
         5'h00: base_of = irq_ctrl_pkg::port_c_pin_irq_base;
         5'h01: base_of = irq_ctrl_pkg::port_r_pin_irq_base;
         5'h02: base_of = irq_ctrl_pkg::rtc_irq_base;
         5'h03: base_of = irq_ctrl_pkg::twi_c_irq_base;
         5'h04: base_of = irq_ctrl_pkg::timer_c0_irq_base;
         5'h05: base_of = irq_ctrl_pkg::timer_c1_irq_base;
         5'h06: base_of = irq_ctrl_pkg::spi_c_vector;
         5'h07: base_of = irq_ctrl_pkg::usart_c0_irq_base;
         5'h08: base_of = irq_ctrl_pkg::nvm_irq_base;
         5'h09: base_of = irq_ctrl_pkg::port_b_pin_irq_base;
         5'h0A: base_of = irq_ctrl_pkg::port_e_pin_irq_base;
         5'h0B: base_of = irq_ctrl_pkg::twi_e_irq_base;
         5'h0C: base_of = irq_ctrl_pkg::timer_e0_irq_base;
         5'h0D: base_of = irq_ctrl_pkg::usart_e0_irq_base;
         5'h0E: base_of = irq_ctrl_pkg::port_d_pin_irq_base;
         5'h0F: base_of = irq_ctrl_pkg::port_a_pin_irq_base;
         5'h10: base_of = irq_ctrl_pkg::comp_a_irq_base;
         5'h11: base_of = irq_ctrl_pkg::adc_a_irq_base;
         5'h12: base_of = irq_ctrl_pkg::timer_d0_irq_base;
         5'h13: base_of = irq_ctrl_pkg::spi_d_vector;
         5'h14: base_of = irq_ctrl_pkg::usart_d0_irq_base;
         5'h15: base_of = irq_ctrl_pkg::port_f_pin_irq_base;
         5'h16: base_of = irq_ctrl_pkg::timer_f0_irq_base;
         default: base_of = irq_ctrl_pkg::reset_vector;
      endcase
   endfunction

   // single-vector units ignore the offset
   function automatic logic is_single(input logic [4:0] i);
      is_single = (i == 5'h06) || (i == 5'h13);
   endfunction

   // offset of a source, forced to zero for single-vector units
   function automatic logic [4:0] ofs_of(input logic [4:0] i,
                                         input logic [4:0] o);
      ofs_of = is_single(i) ? 5'h00 : o;
   endfunction

   // base plus offset, optionally relocated
   function automatic logic [11:0] vec_addr(input logic [11:0] b,
                                           input logic [4:0] ofs,
                                           input logic boot);
      logic [11:0] a;
      a = b + {7'h00, ofs};
      vec_addr = boot ? 12'(a + BOOT_BASE) : a;
   endfunction

   // ****************************************
   // arbitration
   // ****************************************
   logic [NSRC-1:0] lo_req, med_req, hi_req;
   logic lo_hit, med_hit, hi_hit, rr_hit;
   logic [4:0] lo_idx, med_idx, hi_idx, rr_idx;
   logic [4:0] rr_last_q, rr_last_d;

   always_comb begin
      for (int i = 0; i < NSRC; i++) begin
         lo_req[i] = src[i].req && src[i].level == irq_ctrl_pkg::LVL_LOW;
         med_req[i] = src[i].req && src[i].level == irq_ctrl_pkg::LVL_MED;
         hi_req[i] = src[i].req && src[i].level == irq_ctrl_pkg::LVL_HIGH;
      end
   end

   // lowest index is lowest vector address
   always_comb begin
      lo_hit = 1'b0;
      med_hit = 1'b0;
      hi_hit = 1'b0;
      lo_idx = 5'h00;
      med_idx = 5'h00;
      hi_idx = 5'h00;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (lo_req[i]) begin
            lo_hit = 1'b1;
            lo_idx = 5'(i);
         end
         if (med_req[i]) begin
            med_hit = 1'b1;
            med_idx = 5'(i);
         end
         if (hi_req[i]) begin
            hi_hit = 1'b1;
            hi_idx = 5'(i);
         end
      end
   end

   // round-robin: first request after the last one granted
   always_comb begin
      int j;
      j = 0;
      rr_hit = 1'b0;
      rr_idx = 5'h00;
      for (int k = NSRC; k >= 1; k--) begin
         j = (int'(rr_last_q) + k) % NSRC;
         if (lo_req[j]) begin
            rr_hit = 1'b1;
            rr_idx = 5'(j);
         end
      end
   end

   // ****************************************
   // service state
   // ****************************************
   irq_ctrl_pkg::state_t st_q, st_d;
   irq_ctrl_pkg::vec_out_t vec_q, vec_d;
   logic [NSRC-1:0] taken_q, taken_d;
   logic lo_act_q, lo_act_d, med_act_q, med_act_d;
   logic hi_act_q, hi_act_d, nmi_act_q, nmi_act_d;
   logic nmi_seen_q, nmi_seen_d;

   always_comb begin
      logic [4:0] s;
      logic [11:0] a;
      s = 5'h00;
      a = 12'h000;
      st_d = st_q;
      vec_d = vec_q;
      taken_d = '0;
      rr_last_d = rr_last_q;
      lo_act_d = lo_act_q;
      med_act_d = med_act_q;
      hi_act_d = hi_act_q;
      nmi_act_d = nmi_act_q;
      nmi_seen_d = nmi_seen_q && osc_fail;
      // return clears the highest running level
      if (reti) begin
         if (nmi_act_q) nmi_act_d = 1'b0;
         else if (hi_act_q) hi_act_d = 1'b0;
         else if (med_act_q) med_act_d = 1'b0;
         else lo_act_d = 1'b0;
      end
      unique case (st_q)
         irq_ctrl_pkg::ST_IDLE: begin
            if (osc_fail && !nmi_seen_q && !nmi_act_q) begin
               a = vec_addr(irq_ctrl_pkg::osc_fail_vector, 5'h00,
                            vec_in_boot);
               vec_d = '{valid: 1'b1, nmi: 1'b1, level: irq_ctrl_pkg::LVL_HIGH,
                         src: 5'h00, addr: a};
               st_d = irq_ctrl_pkg::ST_WAIT_ACK;
            end else if (!nmi_act_q && hi_en && hi_hit && !hi_act_q) begin
               a = vec_addr(base_of(hi_idx),
                            ofs_of(hi_idx, src[hi_idx].offset),
                            vec_in_boot);
               vec_d = '{valid: 1'b1, nmi: 1'b0, level: irq_ctrl_pkg::LVL_HIGH,
                         src: hi_idx, addr: a};
               st_d = irq_ctrl_pkg::ST_WAIT_ACK;
            end else if (!nmi_act_q && !hi_act_q && med_en && med_hit &&
                         !med_act_q) begin
               a = vec_addr(base_of(med_idx),
                            ofs_of(med_idx, src[med_idx].offset),
                            vec_in_boot);
               vec_d = '{valid: 1'b1, nmi: 1'b0, level: irq_ctrl_pkg::LVL_MED,
                         src: med_idx, addr: a};
               st_d = irq_ctrl_pkg::ST_WAIT_ACK;
            end else if (!nmi_act_q && !hi_act_q && !med_act_q && lo_en &&
                         lo_hit && !lo_act_q) begin
               s = rr_en ? rr_idx : lo_idx;
               a = vec_addr(base_of(s), ofs_of(s, src[s].offset),
                            vec_in_boot);
               vec_d = '{valid: 1'b1, nmi: 1'b0, level: irq_ctrl_pkg::LVL_LOW,
                         src: s, addr: a};
               st_d = irq_ctrl_pkg::ST_WAIT_ACK;
            end
         end
         irq_ctrl_pkg::ST_WAIT_ACK: begin
            if (vec_ack) begin
               vec_d.valid = 1'b0;
               st_d = irq_ctrl_pkg::ST_IDLE;
               if (vec_q.nmi) begin
                  nmi_act_d = 1'b1;
                  nmi_seen_d = 1'b1;
               end else begin
                  taken_d[vec_q.src] = 1'b1;
                  unique case (vec_q.level)
                     irq_ctrl_pkg::LVL_HIGH: hi_act_d = 1'b1;
                     irq_ctrl_pkg::LVL_MED: med_act_d = 1'b1;
                     default: begin
                        lo_act_d = 1'b1;
                        rr_last_d = vec_q.src;
                     end
                  endcase
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= irq_ctrl_pkg::ST_IDLE;
         vec_q <= '0;
         taken_q <= '0;
         rr_last_q <= 5'(NSRC - 1);
         lo_act_q <= 1'b0;
         med_act_q <= 1'b0;
         hi_act_q <= 1'b0;
         nmi_act_q <= 1'b0;
         nmi_seen_q <= 1'b0;
      end else begin
         st_q <= st_d;
         vec_q <= vec_d;
         taken_q <= taken_d;
         rr_last_q <= rr_last_d;
         lo_act_q <= lo_act_d;
         med_act_q <= med_act_d;
         hi_act_q <= hi_act_d;
         nmi_act_q <= nmi_act_d;
         nmi_seen_q <= nmi_seen_d;
      end
   end

   assign vec = vec_q;
   assign src_taken = taken_q;
   assign lo_active = lo_act_q;
   assign med_active = med_act_q;
   assign hi_active = hi_act_q;
   assign nmi_active = nmi_act_q;

endmodule

//--- irq_ctrl_pkg.sv
// constants and types for the multi-level interrupt controller
package irq_ctrl_pkg;

   localparam int VEC_W = 12;
   localparam int OFS_W = 5;
   localparam int NSRC = 24;
   localparam int SRC_W = 5;
   localparam int LVL_W = 2;

   // priority levels
   localparam logic [1:0] LVL_OFF = 2'h0;
   localparam logic [1:0] LVL_LOW = 2'h1;
   localparam logic [1:0] LVL_MED = 2'h2;
   localparam logic [1:0] LVL_HIGH = 2'h3;

   // fixed vectors
   localparam logic [11:0] reset_vector = 12'h000;
   localparam logic [11:0] osc_fail_vector = 12'h002;

   // peripheral bases, ordered by address (source index = position)
   localparam logic [11:0] port_c_pin_irq_base = 12'h004;
   localparam logic [11:0] port_r_pin_irq_base = 12'h008;
   localparam logic [11:0] rtc_irq_base = 12'h014;
   localparam logic [11:0] twi_c_irq_base = 12'h018;
   localparam logic [11:0] timer_c0_irq_base = 12'h01C;
   localparam logic [11:0] timer_c1_irq_base = 12'h028;
   localparam logic [11:0] spi_c_vector = 12'h030;
   localparam logic [11:0] usart_c0_irq_base = 12'h032;
   localparam logic [11:0] nvm_irq_base = 12'h040;
   localparam logic [11:0] port_b_pin_irq_base = 12'h044;
   localparam logic [11:0] port_e_pin_irq_base = 12'h056;
   localparam logic [11:0] twi_e_irq_base = 12'h05A;
   localparam logic [11:0] timer_e0_irq_base = 12'h05E;
   localparam logic [11:0] usart_e0_irq_base = 12'h074;
   localparam logic [11:0] port_d_pin_irq_base = 12'h080;
   localparam logic [11:0] port_a_pin_irq_base = 12'h084;
   localparam logic [11:0] comp_a_irq_base = 12'h088;
   localparam logic [11:0] adc_a_irq_base = 12'h08E;
   localparam logic [11:0] timer_d0_irq_base = 12'h09A;
   localparam logic [11:0] spi_d_vector = 12'h0AE;
   localparam logic [11:0] usart_d0_irq_base = 12'h0B0;
   localparam logic [11:0] port_f_pin_irq_base = 12'h0D0;
   localparam logic [11:0] timer_f0_irq_base = 12'h0D8;

   localparam logic [11:0] BOOT_BASE_DEFAULT = 12'h800;

   // one peripheral request
   typedef struct packed {
      logic req;
      logic [1:0] level;
      logic [4:0] offset;
   } src_req_t;

   // vector handed to the core
   typedef struct packed {
      logic valid;
      logic nmi;
      logic [1:0] level;
      logic [4:0] src;
      logic [11:0] addr;
   } vec_out_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_ACK
   } state_t;

endpackage

//--- irq_ctrl_checker.sv
// assertion checker for the interrupt controller ports
module irq_ctrl_checker #(
   parameter int NSRC = 24,
   parameter logic [11:0] BOOT_BASE = 12'h800
) (
   input wire logic clock, // clock
   input wire logic sys_rst, // reset
   input wire logic osc_fail, // osc fault
   input wire logic vec_in_boot, // moved table
   input wire logic vec_ack, // core ack
   input irq_ctrl_pkg::vec_out_t vec, // vector
   input wire logic [NSRC-1:0] src_taken, // serviced
   input wire logic lo_active, // low busy
   input wire logic med_active, // med busy
   input wire logic hi_active, // high busy
   input wire logic nmi_active // nmi busy
);
   // ****************
   // port checks
   // ****************
   default clocking @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   sequence s_take;
      vec.valid && vec_ack;
   endsequence
   sequence s_nmi_take;
      s_take ##0 vec.nmi;
   endsequence
   a_vec_holds: assert property (vec.valid && !vec_ack |=> $stable(vec))
      else $error("vector changed before ack");
   a_ack_drops: assert property (s_take |=> !vec.valid)
      else $error("vector stays after ack");
   a_taken_pulse: assert property (s_take ##0 !vec.nmi |=>
      src_taken == (NSRC'(1) << $past(vec.src)))
      else $error("wrong source serviced");
   a_nmi_vector: assert property (vec.valid && vec.nmi |->
      vec.addr == (vec_in_boot ? BOOT_BASE + 12'h002 : 12'h002))
      else $error("bad nmi address");
   a_nmi_enter: assert property (s_nmi_take |=> nmi_active)
      else $error("nmi routine not entered");
   a_nmi_take: assert property ($rose(osc_fail) && !vec.valid &&
      !$past(vec.valid) && !nmi_active |-> ##[1:3] (vec.valid && vec.nmi))
      else $error("nmi not offered");
   a_low_enter: assert property (s_take ##0 (vec.level == 2'h1 &&
      !vec.nmi) |=> lo_active && !vec.valid)
      else $error("low routine not entered");
   a_med_preempt: assert property (vec.valid && !vec.nmi &&
      vec.level == 2'h2 |-> !(med_active || hi_active || nmi_active))
      else $error("medium offered over equal or higher");
   a_high_preempt: assert property (vec.valid && !vec.nmi &&
      vec.level == 2'h3 |-> !(hi_active || nmi_active))
      else $error("high offered over high or nmi");
endmodule

bind irq_ctrl irq_ctrl_checker #(.NSRC(NSRC), .BOOT_BASE(BOOT_BASE))
   irq_ctrl_checker_inst (.clock(clock), .sys_rst(sys_rst),
   .osc_fail(osc_fail), .vec_in_boot(vec_in_boot), .vec_ack(vec_ack),
   .vec(vec), .src_taken(src_taken), .lo_active(lo_active),
   .med_active(med_active), .hi_active(hi_active),
   .nmi_active(nmi_active));

//--- irq_core_model.sv
// processor core model that fetches vectors and leaves routines
module irq_core_model (
   input wire logic clock, // clock
   input wire logic sys_rst, // reset
   input irq_ctrl_pkg::vec_out_t vec, // offered vector
   input wire logic busy, // routine running
   input wire logic hold, // stay in routines
   input wire logic [3:0] dly, // fetch delay
   output logic vec_ack, // vector fetched
   output logic reti // routine left
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 4'h0;
         vec_ack <= 1'h0;
         reti <= 1'h0;
      end else begin
         cnt_q <= vec.valid ? cnt_q + 4'h1 : 4'h0;
         vec_ack <= vec.valid && !vec_ack && cnt_q >= dly;
         reti <= busy && !hold && !vec.valid && !reti;
      end
   end
endmodule

//--- multi_level_interrupt_ctrl_test.sv
// self-checking testbench for the interrupt controller
module multi_level_interrupt_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, sys_rst, osc_fail, lo_en, med_en, hi_en, rr_en;
   logic vec_in_boot, vec_ack, reti, hold;
   logic [3:0] dly;
   irq_ctrl_pkg::src_req_t src [24];
   irq_ctrl_pkg::vec_out_t vec;
   logic [23:0] src_taken;
   logic lo_active, med_active, hi_active, nmi_active;
   wire busy = lo_active | med_active | hi_active | nmi_active;
   logic [19:0] exp_q [$];
   logic [19:0] e, g;
   int num_errors = 0;
   int n_tests = 0;
   int seed = 32'hB35E369E;
   logic [11:0] base [23] = '{12'h004, 12'h008, 12'h014, 12'h018,
      12'h01C, 12'h028, 12'h030, 12'h032, 12'h040, 12'h044, 12'h056,
      12'h05A, 12'h05E, 12'h074, 12'h080, 12'h084, 12'h088, 12'h08E,
      12'h09A, 12'h0AE, 12'h0B0, 12'h0D0, 12'h0D8};
   irq_ctrl irq_ctrl_inst (.clock(clock), .sys_rst(sys_rst), .src(src),
      .osc_fail(osc_fail), .lo_en(lo_en), .med_en(med_en), .hi_en(hi_en),
      .rr_en(rr_en), .vec_in_boot(vec_in_boot), .vec_ack(vec_ack),
      .reti(reti), .vec(vec), .src_taken(src_taken),
      .lo_active(lo_active), .med_active(med_active),
      .hi_active(hi_active), .nmi_active(nmi_active));
   irq_core_model irq_core_model_inst (.clock(clock), .sys_rst(sys_rst),
      .vec(vec), .busy(busy), .hold(hold), .dly(dly), .vec_ack(vec_ack),
      .reti(reti));
   // ****************
   // helpers
   // ****************
   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic fire(input int i, input logic [1:0] l,
      input logic [4:0] o);
      logic [11:0] a;
      a = base[i] + ((i == 6 || i == 19) ? 12'h000 : {7'h00, o});
      a = a + (vec_in_boot ? 12'h800 : 12'h000);
      exp_q.push_back({1'h0, l, 5'(i), a});
      src[i] <= '{1'h1, l, o};
   endtask
   task automatic settle;
      for (int k = 0; k < 300 && exp_q.size() != 0; k++) @(posedge clock);
      check(20'(exp_q.size()), 20'h0);
      repeat (8) @(posedge clock);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // peripherals drop a request once it is serviced
   always @(posedge clock) begin
      for (int i = 0; i < 24; i++) if (src_taken[i] === 1'h1) src[i].req <= 1'h0;
   end
   always @(posedge clock) begin
      if (vec.valid === 1'h1 && vec_ack === 1'h1) begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : 20'hFFFFF;
         g = e[19] ? {vec[19], 7'h00, vec[11:0]} : vec[19:0];
         check(g, e);
      end
   end
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   initial begin
      repeat (5000) @(posedge clock);
      num_errors++;
      report_and_stop();
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      sys_rst = 1'h1;
      {osc_fail, rr_en, vec_in_boot, hold} = 4'h0;
      {lo_en, med_en, hi_en} = 3'h7;
      dly = 4'h0;
      foreach (src[i]) src[i] = '0;
      repeat (3) @(posedge clock);
      sys_rst <= 1'h0;
      @(posedge clock);
      check(vec[19:0], 20'h0);
      for (int i = 0; i < 23; i++) begin
         vec_in_boot <= i[0];
         dly <= 4'($random(seed));
         @(posedge clock);
         fire(i, 2'(1 + i % 3), 5'($random(seed) & 3));
         settle();
      end
      $display("vector table sweep done");
      {lo_en, med_en, hi_en, vec_in_boot, hold} <= 5'h01;
      exp_q.push_back(20'h80002);
      osc_fail <= 1'h1;
      settle();
      check(20'(nmi_active), 20'h1);
      {osc_fail, hold} <= 2'h0;
      {lo_en, med_en, hi_en} <= 3'h7;
      repeat (4) @(posedge clock);
      check(20'(nmi_active), 20'h0);
      $display("nmi test done");
      hold <= 1'h1;
      @(posedge clock);
      fire(5, 2'h1, 5'h01);
      settle();
      fire(9, 2'h2, 5'h02);
      settle();
      fire(14, 2'h3, 5'h00);
      settle();
      check(20'({lo_active, med_active, hi_active}), 20'h7);
      hold <= 1'h0;
      repeat (12) @(posedge clock);
      check(20'(busy), 20'h0);
      $display("pre-emption test done");
      lo_en <= 1'h0;
      @(posedge clock);
      fire(3, 2'h1, 5'h00);
      fire(7, 2'h1, 5'h00);
      lo_en <= 1'h1;
      settle();
      $display("fixed low order done");
      {lo_en, rr_en} <= 2'h1;
      @(posedge clock);
      fire(14, 2'h1, 5'h00);
      fire(3, 2'h1, 5'h00);
      fire(7, 2'h1, 5'h00);
      lo_en <= 1'h1;
      settle();
      $display("round-robin low order done");
      report_and_stop();
   end
endmodule
